// ===== logic/asw_pkg.sv
// package for the static memory host controller: register map, pin groups, timing
package asw_pkg;

    // ****************************************
    // register map of the command port
    // ****************************************
    localparam logic [3:0] ASW_REG_CTRL = 4'h0;
    localparam logic [3:0] ASW_REG_ADDR = 4'h1;
    localparam logic [3:0] ASW_REG_WDATA = 4'h2;
    localparam logic [3:0] ASW_REG_RDATA = 4'h3;
    localparam logic [3:0] ASW_REG_STATUS = 4'h4;

    // ctrl fields
    localparam int ASW_CTRL_GO_BIT = 0;
    localparam int ASW_CTRL_WRITE_BIT = 1;
    localparam int ASW_CTRL_LANE_LO_BIT = 2;
    localparam int ASW_CTRL_LANE_HI_BIT = 3;
    localparam int ASW_CTRL_WIDTH_BIT = 4;
    localparam int ASW_CTRL_RETAIN_BIT = 5;
    localparam logic [5:0] ASW_CTRL_RESET = 6'h1C;

    // status fields
    localparam int ASW_STAT_BUSY_BIT = 0;
    localparam int ASW_STAT_DONE_BIT = 1;
    localparam int ASW_STAT_REFUSED_BIT = 2;

    // ****************************************
    // memory organisation
    // ****************************************
    localparam int ASW_WORD_ADDR_W = 18;
    localparam int ASW_BYTE_ADDR_W = 19;
    localparam int ASW_DATA_W = 16;
    localparam int ASW_WORD_COUNT = 262144;
    localparam int ASW_BYTE_COUNT = 524288;

    // ****************************************
    // timing at 25 MHz
    // ****************************************
    localparam int ASW_CLK_PERIOD_NS = 40;
    localparam int ASW_CYCLE_NS = 85;
    localparam int ASW_CYCLE_CYC = (ASW_CYCLE_NS + ASW_CLK_PERIOD_NS - 1) / ASW_CLK_PERIOD_NS;
    localparam logic [1:0] ASW_CYCLE_CNT = 2'(ASW_CYCLE_CYC);

    // ****************************************
    // memory pin group
    // ****************************************
    typedef struct packed {
        logic select_active_low;
        logic select_active_high;
        logic output_enable_n;
        logic write_strobe_n;
        logic lower_lane_enable_n;
        logic upper_lane_enable_n;
        logic byte_extra_address_bit;
        logic width_organisation_select;
        logic [ASW_WORD_ADDR_W-1:0] word_address_inputs;
    } asw_pins_t;

    localparam asw_pins_t ASW_PINS_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 18'h0};

    typedef enum logic [1:0] {
        ASW_IDLE = 2'b00,
        ASW_READ = 2'b01,
        ASW_WRITE = 2'b10,
        ASW_END = 2'b11
    } asw_state_t;

endpackage

// ===== logic/asw_host.sv
// host controller driving an asynchronous word/byte static memory
// ****************************************
// Summary of operation
// [RULE1] deselect memory by select_active_low high and select_active_high low when idle
// [RULE2] word mode gives 262144 words, byte mode 524288 bytes
// [RULE3] width select changes only while idle, never during an access; a width written the cycle before a go reaches the pin with the selects
// [RULE4] word mode ignores the extra address bit
// [RULE5] byte mode uses the extra address bit as lowest address bit
// [RULE6] byte mode ignores both lane enables
// [RULE7] byte mode uses only the lower eight data lines
// [RULE8] word read: selects active, output enable low, write strobe high
// [RULE9] byte read: same selects, addressed byte on lower lane
// [RULE10] output enable high floats memory outputs
// [RULE11] lower lane write: lower enable low, upper enable high
// [RULE12] upper lane write: upper enable low, lower enable high
// [RULE13] word write: both lane enables low
// [RULE14] word writes may be timed by any of four signals
// [RULE15] byte write timed by selects and write strobe overlap
// [RULE16] memory floats data while deselected, output disabled or lanes off
// [RULE17] host never drives data lines while memory outputs are active
// [RULE18] no access while in low voltage retention; code refuses a go only if the retain bit is already set
// [RULE19] write strobe held high for the whole read cycle
// [RULE20] memory floats during select-timed write regardless of output enable
// [RULE21] lower enable governs lines 1-8, upper enable lines 9-16
// ****************************************
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module asw_host
    import asw_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output asw_pins_t pins,
    input wire logic [ASW_DATA_W-1:0] data_in,
    output logic [ASW_DATA_W-1:0] data_out,
    output logic [ASW_DATA_W-1:0] data_oe_n
);

    // ****************************************
    // state
    // ****************************************
    asw_state_t state_reg, state_next;
    logic [5:0] ctrl_reg, ctrl_next;
    logic [ASW_BYTE_ADDR_W-1:0] addr_reg, addr_next;
    logic [ASW_DATA_W-1:0] wdata_reg, wdata_next;
    logic [ASW_DATA_W-1:0] rdata_reg, rdata_next;
    logic done_reg, done_next;
    logic refused_reg, refused_next;
    logic [1:0] cnt_reg, cnt_next;
    logic [31:0] rd_reg, rd_next;
    asw_pins_t pins_reg, pins_next;
    logic [ASW_DATA_W-1:0] oe_n_reg, oe_n_next;
    logic [ASW_DATA_W-1:0] sync1_reg, sync2_reg;

    logic word_mode;
    logic go_req;
    assign word_mode = ctrl_reg[ASW_CTRL_WIDTH_BIT];
    assign go_req = wr && addr == ASW_REG_CTRL && wdata[ASW_CTRL_GO_BIT];

    // pin inputs are asynchronous to clk
    always_ff @(posedge clk) begin
        sync1_reg <= data_in;
        sync2_reg <= sync1_reg;
    end

    always_comb begin
        state_next = state_reg;
        ctrl_next = ctrl_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        done_next = done_reg;
        refused_next = refused_reg;
        cnt_next = cnt_reg;
        rd_next = 32'h00000000;
        pins_next = pins_reg;
        oe_n_next = {ASW_DATA_W{1'b1}};
        // register writes
        if (wr) begin
            case (addr)
                ASW_REG_CTRL: begin
                    // [RULE3] width locked during access
                    if (state_reg == ASW_IDLE) begin
                        ctrl_next = wdata[5:0] & ~(6'h01);
                        // a go keeps the standing width, but a width written the cycle before still moves the pin as the access starts
                        if (wdata[ASW_CTRL_GO_BIT]) begin
                            ctrl_next[ASW_CTRL_WIDTH_BIT] = ctrl_reg[ASW_CTRL_WIDTH_BIT];
                        end
                    end else begin
                        ctrl_next[ASW_CTRL_RETAIN_BIT] = wdata[ASW_CTRL_RETAIN_BIT];
                    end
                end
                ASW_REG_ADDR: addr_next = wdata[ASW_BYTE_ADDR_W-1:0];
                ASW_REG_WDATA: wdata_next = wdata[ASW_DATA_W-1:0];
                ASW_REG_STATUS: begin
                    done_next = 1'b0;
                    refused_next = 1'b0;
                end
                default: ;
            endcase
        end
        if (rd) begin
            case (addr)
                ASW_REG_CTRL: rd_next = {26'h0, ctrl_reg};
                ASW_REG_ADDR: rd_next = {13'h0, addr_reg};
                ASW_REG_WDATA: rd_next = {16'h0000, wdata_reg};
                ASW_REG_RDATA: rd_next = {16'h0000, rdata_reg};
                ASW_REG_STATUS: rd_next = {29'h0, refused_reg, done_reg, state_reg != ASW_IDLE};
                default: rd_next = 32'h00000000;
            endcase
        end
        case (state_reg)
            ASW_IDLE: begin
                // [RULE1] deselected while idle
                pins_next = ASW_PINS_IDLE;
                pins_next.width_organisation_select = word_mode;
                if (go_req) begin
                    // [RULE18] go refused only if the retain bit is already set; a running access is not stopped
                    if (ctrl_reg[ASW_CTRL_RETAIN_BIT] || (state_reg != ASW_IDLE)) begin
                        refused_next = 1'b1;
                    end else begin
                        done_next = 1'b0;
                        cnt_next = ASW_CYCLE_CNT;
                        pins_next.select_active_low = 1'b0;
                        pins_next.select_active_high = 1'b1;
                        // [RULE4] [RULE5] extra bit only in byte mode
                        if (word_mode) begin
                            pins_next.word_address_inputs = addr_reg[ASW_WORD_ADDR_W-1:0];
                            pins_next.byte_extra_address_bit = 1'b0;
                        end else begin
                            pins_next.word_address_inputs = addr_reg[ASW_BYTE_ADDR_W-1:1];
                            pins_next.byte_extra_address_bit = addr_reg[0];
                        end
                        // [RULE6] [RULE11] [RULE12] [RULE13] lane enables
                        pins_next.lower_lane_enable_n = word_mode ? ~wdata[ASW_CTRL_LANE_LO_BIT] : 1'b1;
                        pins_next.upper_lane_enable_n = word_mode ? ~wdata[ASW_CTRL_LANE_HI_BIT] : 1'b1;
                        if (wdata[ASW_CTRL_WRITE_BIT]) begin
                            // [RULE14] [RULE15] write timed by write strobe, output enable held high
                            pins_next.write_strobe_n = 1'b0;
                            pins_next.output_enable_n = 1'b1;
                            state_next = ASW_WRITE;
                        end else begin
                            // [RULE8] [RULE9] [RULE19] read with write strobe high
                            pins_next.write_strobe_n = 1'b1;
                            pins_next.output_enable_n = 1'b0;
                            state_next = ASW_READ;
                        end
                    end
                end
            end
            ASW_READ: begin
                // [RULE17] host lines stay undriven during a read
                cnt_next = cnt_reg - 2'd1;
                if (cnt_reg == 2'd0) begin
                    rdata_next = sync2_reg;
                    // [RULE7] [RULE21] only enabled lanes are kept in word mode, only the lower lane in byte mode
                    if (!word_mode || pins_reg.upper_lane_enable_n) begin
                        rdata_next[15:8] = 8'h00;
                    end
                    if (word_mode && pins_reg.lower_lane_enable_n) begin
                        rdata_next[7:0] = 8'h00;
                    end
                    pins_next.output_enable_n = 1'b1;
                    state_next = ASW_END;
                end
            end
            ASW_WRITE: begin
                // [RULE7] [RULE21] drive only lanes being written
                oe_n_next[7:0] = {8{word_mode && pins_reg.lower_lane_enable_n}};
                oe_n_next[15:8] = {8{!word_mode || pins_reg.upper_lane_enable_n}};
                cnt_next = cnt_reg - 2'd1;
                if (cnt_reg == 2'd0) begin
                    pins_next.write_strobe_n = 1'b1;
                    state_next = ASW_END;
                end
            end
            ASW_END: begin
                // data held one more cycle after strobe rises, then deselect
                oe_n_next = oe_n_reg;
                pins_next = ASW_PINS_IDLE;
                pins_next.width_organisation_select = word_mode;
                oe_n_next = {ASW_DATA_W{1'b1}};
                done_next = 1'b1;
                state_next = ASW_IDLE;
            end
            default: state_next = ASW_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= ASW_IDLE;
            ctrl_reg <= ASW_CTRL_RESET;
            addr_reg <= 19'h0;
            wdata_reg <= 16'h0000;
            rdata_reg <= 16'h0000;
            done_reg <= 1'b0;
            refused_reg <= 1'b0;
            cnt_reg <= 2'h0;
            rd_reg <= 32'h00000000;
            pins_reg <= ASW_PINS_IDLE;
            oe_n_reg <= 16'hFFFF;
        end else begin
            state_reg <= state_next;
            ctrl_reg <= ctrl_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            done_reg <= done_next;
            refused_reg <= refused_next;
            cnt_reg <= cnt_next;
            rd_reg <= rd_next;
            pins_reg <= pins_next;
            oe_n_reg <= oe_n_next;
        end
    end

    assign rdata = rd_reg;
    assign pins = pins_reg;
    assign data_out = wdata_reg;
    assign data_oe_n = oe_n_reg;

endmodule
`default_nettype wire

// ===== test/asw_host_properties.sv
// port assertions for the static memory host
`timescale 1ns/10ps
`default_nettype none
module asw_host_chk
    import asw_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire asw_pins_t pins,
    input wire logic [ASW_DATA_W-1:0] data_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    idle_after_reset_a: assert property ($past(srst) |-> pins == ASW_PINS_IDLE)
        else $error("pins not idle");
    select_pair_a: assert property (pins.select_active_low == !pins.select_active_high)
        else $error("selects disagree");
    read_strobe_high_a: assert property (!pins.output_enable_n |-> pins.write_strobe_n)
        else $error("strobe low in read");
    no_contention_a: assert property (!pins.output_enable_n |-> &data_oe_n)
        else $error("host drives in read");
    byte_upper_float_a: assert property (!pins.width_organisation_select |-> &data_oe_n[15:8])
        else $error("upper lane driven");
    drive_selected_a: assert property (!(&data_oe_n) |-> !pins.select_active_low)
        else $error("drive while deselected");
    write_len_a: assert property ($fell(pins.write_strobe_n) |->
        !pins.write_strobe_n [*4] ##1 pins.write_strobe_n) else $error("strobe length");
    lane_drive_a: assert property ($fell(pins.write_strobe_n) && pins.width_organisation_select |=>
        data_oe_n == {{8{pins.upper_lane_enable_n}}, {8{pins.lower_lane_enable_n}}}) else $error("lane drive");
endmodule
bind asw_host asw_host_chk u_chk (.clk(clk), .srst(srst), .pins(pins), .data_oe_n(data_oe_n));
`default_nettype wire

// ===== test/asw_mem_model.sv
// behavioural static memory on the far side of the host
`timescale 1ns/10ps
`default_nettype none
module asw_mem_model
    import asw_pkg::*;
(
    input wire asw_pins_t pins,
    input wire logic [ASW_DATA_W-1:0] bus,
    output logic [ASW_DATA_W-1:0] mem_q
);
    logic [15:0] wmem [ASW_WORD_COUNT];
    logic [7:0] bmem [ASW_BYTE_COUNT];
    logic sel, word, rdg;
    logic [18:0] ba;
    logic [15:0] val, drv;
    assign sel = !pins.select_active_low && pins.select_active_high;
    assign word = pins.width_organisation_select;
    assign ba = {pins.word_address_inputs, pins.byte_extra_address_bit};
    assign rdg = sel && !pins.output_enable_n && pins.write_strobe_n;
    // lanes follow enables, byte mode lower only
    assign drv = !rdg ? 16'h0 : !word ? 16'h00FF : {{8{!pins.upper_lane_enable_n}}, {8{!pins.lower_lane_enable_n}}};
    assign val = word ? wmem[pins.word_address_inputs] : {8'h00, bmem[ba]};
    // released lines show the inverse so a stale value never passes
    assign mem_q = ~(val ^ drv);
    always @(posedge pins.write_strobe_n) begin
        if (sel && word) begin
            if (!pins.lower_lane_enable_n) wmem[pins.word_address_inputs][7:0] = bus[7:0];
            if (!pins.upper_lane_enable_n) wmem[pins.word_address_inputs][15:8] = bus[15:8];
        end else if (sel) begin
            bmem[ba] = bus[7:0];
        end
    end
endmodule
`default_nettype wire

// ===== test/asw_host_tb_top.sv
// self-checking bench for the static memory host
`timescale 1ns/10ps
`default_nettype none
module asw_host_tb_top
    import asw_pkg::*;
;
    logic clk, srst, wr, rd, rd_d;
    logic [3:0] addr;
    logic [31:0] wdata, rdata;
    asw_pins_t pins;
    logic [15:0] data_in, data_out, data_oe_n, mem_q, d0, d1, mk;
    logic [17:0] wa;
    logic [1:0] ln;
    logic [31:0] exp_q [$];
    int fails, n_tests;
    assign data_in = (data_out & ~data_oe_n) | (mem_q & data_oe_n);
    asw_host u_dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .pins(pins), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));
    asw_mem_model u_mem (.pins(pins), .bus(data_in), .mem_q(mem_q));
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        rd <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rreg(input logic [3:0] a, input logic [31:0] e);
        addr <= a;
        rd <= 1'h1;
        wr <= 1'h0;
        exp_q.push_back(e);
        @(posedge clk);
    endtask
    task automatic idle(input int n);
        wr <= 1'h0;
        rd <= 1'h0;
        repeat (n) @(posedge clk);
    endtask
    // one access; for a read d is the expected data
    task automatic acc(input logic w, input logic [1:0] l, input logic wd, input logic [18:0] a, input logic [15:0] d);
        wreg(ASW_REG_ADDR, {13'h0, a});
        wreg(ASW_REG_WDATA, {16'h0, d});
        // width register settles while idle, the go keeps it; the pin moves with the selects
        wreg(ASW_REG_CTRL, {26'h0, 1'h0, wd, l, w, 1'h0});
        wreg(ASW_REG_CTRL, {26'h0, 1'h0, wd, l, w, 1'h1});
        idle(6);
        rreg(ASW_REG_STATUS, 32'h2);
        if (!w) rreg(ASW_REG_RDATA, {16'h0, d});
    endtask
    task automatic results;
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) begin
        if (rd_d) begin
            n_tests++;
            if (rdata !== exp_q[0]) begin
                fails++;
                $display("BAD %0t rdata %h want %h", $time, rdata, exp_q[0]);
            end
            void'(exp_q.pop_front());
        end
    end
    initial begin
        #400000;
        fails++;
        results();
    end
    initial begin
        {srst, wr, rd, addr, wdata, rd_d, fails, n_tests} = '0;
        srst = 1'h1;
        void'($urandom(64));
        repeat (20) @(posedge clk);
        srst <= 1'h0;
        rreg(ASW_REG_CTRL, 32'h1C);
        rreg(4'hF, 32'h0);
        rreg(ASW_REG_STATUS, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 6; i++) begin
            wa = 18'($urandom);
            d0 = 16'($urandom);
            d1 = 16'($urandom);
            ln = 2'(i % 3 + 1);
            mk = {{8{ln[1]}}, {8{ln[0]}}};
            acc(1'h1, 2'h3, 1'h1, {1'h0, wa}, d0);
            acc(1'h1, ln, 1'h1, {1'h0, wa}, d1);
            acc(1'h0, 2'h3, 1'h1, {1'h0, wa}, (d1 & mk) | (d0 & ~mk));
            acc(1'h0, ln, 1'h1, {1'h0, wa}, d1 & mk);
            acc(1'h1, 2'h0, 1'h0, {wa, 1'h0}, {8'h00, d0[7:0]});
            acc(1'h1, ln, 1'h0, {wa, 1'h1}, {8'h00, d1[7:0]});
            acc(1'h0, 2'h1, 1'h0, {wa, 1'h0}, {8'h00, d0[7:0]});
            acc(1'h0, 2'h2, 1'h0, {wa, 1'h1}, {8'h00, d1[7:0]});
        end
        $display("word and byte test done");
        wreg(ASW_REG_STATUS, 32'h0);
        wreg(ASW_REG_CTRL, 32'h3C);
        wreg(ASW_REG_CTRL, 32'h3D);
        idle(3);
        rreg(ASW_REG_STATUS, 32'h4);
        wreg(ASW_REG_CTRL, 32'h1C);
        idle(3);
        $display("retention test done");
        results();
    end
endmodule
`default_nettype wire
